// ---- rtl/twc_pkg.sv ----
// Purpose: Shared constants and carriers for the terminal write/erase/cursor control
// Assumes: Timing phase pulses come from the terminal's own sequencer on clk_sys
// Notes: Shared codes and counts live here; NSYNC stays in twc_ctrl
package twc_pkg;
    // ************************************
    // Bus and character codes
    // ************************************
    localparam int BUS_W = 8;
    localparam logic [7:0] SPACE_CODE = 8'h20;
    localparam int FIFO_DEPTH = 8;
    // ************************************
    // Cursor geometry
    // ************************************
    localparam int HCOUNT_MOD = 20;
    localparam int VCOUNT_MOD = 12;
    localparam int BLOCK_MOD = 4;
    localparam int PAGE_SIZE = 960;
    localparam logic [4:0] H_LAST = 5'h13;
    localparam logic [3:0] V_LAST = 4'hb;
    localparam logic [1:0] B_LAST = 2'h3;
    // ************************************
    // Timing
    // ************************************
    localparam int CLK_NS = 100;
    localparam int PAGE_ERASE_US = 1000;
    localparam int PAGE_ERASE_CYC = (PAGE_ERASE_US * 1000) / CLK_NS;

    // Special character indications from the detector
    typedef struct packed {
        logic carriage_return;
        logic line_feed;
        logic back_space;
        logic bell;
        logic control_char;
        logic rubout;
        logic space_here;
    } twc_special_t;

    // Timing pulses of the sequencer
    typedef struct packed {
        logic cycle_2;
        logic cycle_3;
        logic cursor_move_pulse;
        logic bus_transfer_pulse;
        logic home_latch_pulse;
    } twc_timing_t;

    // Cursor count commands toward the counter board
    typedef struct packed {
        logic h_up;
        logic h_down;
        logic h_clear;
        logic v_up;
        logic v_down;
    } twc_cursor_t;

    // Bus enables for one transfer
    typedef struct packed {
        logic ram_write;
        logic serial_load;
        logic parallel_load;
        logic space_drive;
    } twc_bus_t;
endpackage : twc_pkg

// ---- rtl/twc_fifo.sv ----
// Purpose: Small synchronous FIFO for received characters
// Assumes: Single clock, ready/valid on both sides
// Notes: Full and empty derive from an occupancy count
module twc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : twc_fifo

// ---- rtl/twc_ctrl.sv ----
// Purpose: Write, erase and cursor control of a character video terminal
// Assumes: Timing pulses are one-cycle strobes on clk_sys; keys are raw pins
// Notes: Received characters pass an 8-word FIFO before the write cycle
//
// Functional notes
// - Erase-line key sets erase flag on cycle 2
// - Erase flag: advance counter, write spaces
// - Short form stops erase at h end
// - Long form needs h and block end
// - Cycle 3 clears the erase flag
// - Erase-page key holds erase flag set
// - Erase-page sets home-pending for after erase
// - Cursor key gives one pulse on 1C
// - H up right, down left; V up down
// - Cycle 3 clears four cursor-key latches
// - Home copies start-of-page at 7C end
// - Scan row advances V, not retrace/plot
// - Scan h count-ups blocked during blanking
// - Write advance blocked by defeat or no-wrap
// - Data available selects buffers on 0B2
// - Transfer waits for both output buffers empty
// - Normal mode: controls sent, not stored
// - Plot mode stores all, moves right
// - Normal: CR stored only onto space
// - CR home-of-line, LF down, BS left
// - Transfers advance h on 1C, except normal-mode controls
// - One 8-bit bus, enables set direction
// - Special moves happen on cycle 1C
module twc_ctrl
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire twc_pkg::twc_timing_t timing,
    input wire logic erase_line_key,
    input wire logic erase_page_key,
    input wire logic home_key,
    input wire logic [3:0] cursor_keys,
    input wire logic scan_active,
    input wire logic vertical_blank_n,
    input wire logic scan_h_count,
    input wire logic scan_row_end,
    input wire logic short_form,
    input wire logic plot_mode,
    input wire logic auto_carry,
    input wire logic count_up_defeat,
    input wire logic line_end_no_wrap,
    input wire logic h_line_end,
    input wire logic block_line_end,
    input wire logic serial_rx_available,
    input wire logic parallel_key_available,
    input wire logic serial_tx_empty,
    input wire logic parallel_out_empty,
    input wire logic [twc_pkg::BUS_W-1:0] rx_data,
    input wire twc_pkg::twc_special_t special,
    output logic rx_ready,
    output logic [twc_pkg::BUS_W-1:0] bus_data,
    output twc_pkg::twc_bus_t bus_en,
    output twc_pkg::twc_cursor_t cursor_cmd,
    output logic home_load,
    output logic erase_busy
);
    import twc_pkg::*;

    // ************************************
    // Pin synchronisers
    // ************************************
    localparam int NSYNC = 13;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic erase_line_s, erase_page_s, home_s, serial_rx_s, parallel_key_s, serial_empty_s;
    logic parallel_empty_s, vertical_blank_s, auto_carry_s;
    logic [3:0] cursor_keys_s;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_a <= '0;
            sync_b <= '0;
        end
        else
        begin
            sync_a <= {erase_line_key, erase_page_key, home_key, cursor_keys, serial_rx_available,
                       parallel_key_available, serial_tx_empty, parallel_out_empty, vertical_blank_n, auto_carry};
            sync_b <= sync_a;
        end
    end

    assign {erase_line_s, erase_page_s, home_s, cursor_keys_s, serial_rx_s, parallel_key_s,
            serial_empty_s, parallel_empty_s, vertical_blank_s, auto_carry_s} = sync_b;

    // ************************************
    // Received data buffer
    // ************************************
    logic data_avail, fifo_in_ready, fifo_out_valid, sinks_ready, take_char, erase_flag;
    logic [BUS_W-1:0] fifo_out_data;

    assign data_avail = serial_rx_s || parallel_key_s;
    assign sinks_ready = serial_empty_s && parallel_empty_s;
    // Transfers pause during erase since the bus carries spaces then
    assign take_char = timing.bus_transfer_pulse && fifo_out_valid && sinks_ready && !erase_flag;

    twc_fifo #(
        .WIDTH(BUS_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_data(rx_data),
        .in_valid(data_avail),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(take_char)
    );

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_ready <= 1'b0;
        end
        else
        begin
            // Back-pressure toward the I/O board
            rx_ready <= fifo_in_ready;
        end
    end

    // ************************************
    // Erase control
    // ************************************
    logic home_pending, erase_stop;

    // Stop condition depends on layout
    assign erase_stop = short_form ? h_line_end : (h_line_end && block_line_end);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            erase_flag <= 1'b0;
        end
        else if (erase_page_s)
        begin
            erase_flag <= 1'b1;
        end
        else if (timing.cycle_3)
        begin
            erase_flag <= 1'b0;
        end
        else if (timing.cycle_2 && erase_line_s)
        begin
            erase_flag <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            home_pending <= 1'b0;
        end
        else if (erase_page_s)
        begin
            home_pending <= 1'b1;
        end
        else if (home_load)
        begin
            home_pending <= 1'b0;
        end
    end

    // ************************************
    // Cursor key latches
    // ************************************
    logic [3:0] key_latch;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            key_latch <= '0;
        end
        else
        begin
            // Set beats clear so a key seen on cycle 3 is kept
            for (int i = 0; i < 4; i++)
            begin
                if (scan_active && cursor_keys_s[i])
                begin
                    key_latch[i] <= 1'b1;
                end
                else if (timing.cycle_3 || timing.cursor_move_pulse)
                begin
                    key_latch[i] <= 1'b0;
                end
            end
        end
    end

    // ************************************
    // Write cycle decode
    // ************************************
    logic is_control;
    logic store_char;
    logic transfer_done;
    twc_special_t held_special;
    logic held_defeat;

    assign is_control = special.control_char || special.rubout || special.carriage_return ||
                        special.line_feed || special.back_space || special.bell;
    // Plot stores all; normal stores CR only onto a space
    assign store_char = plot_mode || !is_control || (special.carriage_return && special.space_here);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_en <= '0;
            bus_data <= '0;
        end
        else if (erase_flag && !erase_stop)
        begin
            bus_en <= '{ram_write: 1'b1, serial_load: 1'b0, parallel_load: 1'b0, space_drive: 1'b1};
            bus_data <= SPACE_CODE;
        end
        else if (take_char)
        begin
            // Outputs always loaded, RAM only when storable
            bus_en <= '{ram_write: store_char, serial_load: 1'b1, parallel_load: 1'b1,
                        space_drive: 1'b0};
            bus_data <= fifo_out_data;
        end
        else
        begin
            bus_en <= '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            transfer_done <= 1'b0;
            held_special <= '0;
            held_defeat <= 1'b0;
        end
        else if (take_char)
        begin
            transfer_done <= 1'b1;
            held_special <= plot_mode ? '0 : special;
            held_defeat <= !plot_mode && is_control;
        end
        else if (timing.cursor_move_pulse)
        begin
            transfer_done <= 1'b0;
        end
    end

    // ************************************
    // Cursor commands
    // ************************************
    logic write_adv, scan_h, scan_v, erase_adv;

    assign write_adv = transfer_done && !held_defeat && !count_up_defeat && !line_end_no_wrap;
    assign scan_h = scan_h_count && vertical_blank_s;
    assign scan_v = scan_row_end && vertical_blank_s && !plot_mode;
    assign erase_adv = erase_flag && !erase_stop && !auto_carry_s && !auto_carry_s;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cursor_cmd <= '0;
        end
        else
        begin
            cursor_cmd.h_up <= scan_h || erase_adv || (erase_flag && !erase_stop) ||
                               (timing.cursor_move_pulse && (write_adv || key_latch[0]));
            cursor_cmd.h_down <= timing.cursor_move_pulse &&
                                 (key_latch[1] || (transfer_done && held_special.back_space));
            cursor_cmd.h_clear <= timing.cursor_move_pulse && transfer_done && held_special.carriage_return;
            cursor_cmd.v_up <= scan_v || (timing.cursor_move_pulse &&
                               (key_latch[2] || (transfer_done && held_special.line_feed)));
            cursor_cmd.v_down <= timing.cursor_move_pulse && key_latch[3];
        end
    end

    // ************************************
    // Home load and status
    // ************************************
    logic home_pulse_d;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            home_pulse_d <= 1'b0;
            home_load <= 1'b0;
            erase_busy <= 1'b0;
        end
        else
        begin
            home_pulse_d <= timing.home_latch_pulse;
            // Trailing edge of 7C loads the start-of-page value
            home_load <= home_pulse_d && !timing.home_latch_pulse &&
                         (home_s || (home_pending && !erase_flag));
            erase_busy <= erase_flag;
        end
    end

    // ************************************
    // Checks
    // ************************************
    property p_erase_set;
        @(posedge clk_sys) disable iff (!rst_n)
        (timing.cycle_2 && erase_line_s && !timing.cycle_3) |=> erase_flag;
    endproperty
    a_erase_set: assert property (p_erase_set) else $error("erase flag not set");

    property p_erase_clr;
        @(posedge clk_sys) disable iff (!rst_n)
        (timing.cycle_3 && !erase_page_s) |=> !erase_flag;
    endproperty
    a_erase_clr: assert property (p_erase_clr) else $error("erase flag not cleared");

    property p_page_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        erase_page_s |=> (erase_flag && home_pending);
    endproperty
    a_page_hold: assert property (p_page_hold) else $error("page erase not held");

    property p_space;
        @(posedge clk_sys) disable iff (!rst_n)
        bus_en.space_drive |-> (bus_data == SPACE_CODE && bus_en.ram_write);
    endproperty
    a_space: assert property (p_space) else $error("erase not writing space");

    property p_sinks;
        @(posedge clk_sys) disable iff (!rst_n)
        (bus_en.serial_load) |-> $past(sinks_ready);
    endproperty
    a_sinks: assert property (p_sinks) else $error("transfer while sink busy");

    property p_key_clr;
        @(posedge clk_sys) disable iff (!rst_n)
        (timing.cycle_3 && !scan_active) |=> (key_latch == 4'h0);
    endproperty
    a_key_clr: assert property (p_key_clr) else $error("cursor latches not cleared");

    property p_vblank;
        @(posedge clk_sys) disable iff (!rst_n)
        (!vertical_blank_s && !timing.cursor_move_pulse) |=> !cursor_cmd.v_up;
    endproperty
    a_vblank: assert property (p_vblank) else $error("row advance in retrace");

    property p_normal_ctl;
        @(posedge clk_sys) disable iff (!rst_n)
        (take_char && !erase_flag && !plot_mode && special.rubout && !special.carriage_return)
        |=> (!bus_en.ram_write && bus_en.serial_load && bus_en.parallel_load);
    endproperty
    a_normal_ctl: assert property (p_normal_ctl) else $error("control stored in normal mode");
endmodule : twc_ctrl

// ---- tb/twc_io_model.sv ----
// Purpose: Behavioural I/O board with character sources and the two output sinks
// Assumes: The bench raises req for one clock to offer one character
// Notes: Sources alternate between the serial and the parallel/keyboard input
module twc_io_model (
    input wire logic clk_sys,
    input wire logic req,
    input wire logic [7:0] req_data,
    input wire twc_pkg::twc_special_t req_spec,
    input wire logic hold_busy,
    input wire twc_pkg::twc_bus_t bus_en,
    output logic serial_rx_available,
    output logic parallel_key_available,
    output logic [7:0] rx_data,
    output twc_pkg::twc_special_t special,
    output logic serial_tx_empty,
    output logic parallel_out_empty
);
    timeunit 1ns;
    timeprecision 1ns;
    import twc_pkg::*;
    logic use_par = 1'b0;
    logic [2:0] hold_cnt = 3'h0;
    logic [1:0] ser_busy = 2'h0;
    logic [1:0] par_busy = 2'h0;

    initial
    begin
        serial_rx_available = 1'b0;
        parallel_key_available = 1'b0;
        rx_data = 8'h00;
        special = '0;
    end

    // ************************************
    // Sources
    // ************************************
    // Data wanders once its hold runs out, so a late sample shows up
    always @(posedge clk_sys)
    begin
        serial_rx_available <= #10 req & ~use_par;
        parallel_key_available <= #10 req & use_par;
        if (req)
        begin
            rx_data <= #10 req_data;
            special <= #10 req_spec;
            use_par <= ~use_par;
            hold_cnt <= 3'h6;
        end
        else if (hold_cnt != 3'h0)
        begin
            hold_cnt <= hold_cnt - 3'h1;
            if (hold_cnt == 3'h1)
                rx_data <= #10 ~rx_data;
        end
    end

    // ************************************
    // Sinks
    // ************************************
    // A loaded sink stays busy a few cycles, like a shifting transmitter
    always @(posedge clk_sys)
    begin
        if (bus_en.serial_load)
            ser_busy <= #10 2'h3;
        else if (ser_busy != 2'h0)
            ser_busy <= #10 ser_busy - 2'h1;
        if (bus_en.parallel_load)
            par_busy <= #10 2'h3;
        else if (par_busy != 2'h0)
            par_busy <= #10 par_busy - 2'h1;
    end

    assign serial_tx_empty = ~hold_busy & (ser_busy == 2'h0);
    assign parallel_out_empty = ~hold_busy & (par_busy == 2'h0);
endmodule : twc_io_model

// ---- tb/tb_twc_ctrl.sv ----
// Purpose: Self-checking bench for the write, erase and cursor control
// Assumes: Sequencer pulses are strobed by the bench; the I/O board is modelled
// Notes: Outputs are gathered over a short window after each strobe
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end

module tb_twc_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import twc_pkg::*;
    localparam logic [4:0] T2 = 5'h10;
    localparam logic [4:0] T3 = 5'h08;
    localparam logic [4:0] T1C = 5'h04;
    localparam logic [4:0] T0B2 = 5'h02;
    localparam logic [4:0] T7C = 5'h01;
    logic clk_sys, rst_n, req, hold_busy, rx_ready, home_load, erase_busy;
    twc_timing_t timing;
    logic erase_line_key, erase_page_key, home_key, scan_active, vertical_blank_n, scan_h_count, scan_row_end;
    logic short_form, plot_mode, auto_carry, count_up_defeat, line_end_no_wrap, h_line_end, block_line_end;
    logic [3:0] cursor_keys;
    logic serial_rx_available, parallel_key_available, serial_tx_empty, parallel_out_empty;
    logic [BUS_W-1:0] rx_data, bus_data, last_data, req_data;
    twc_special_t special, req_spec;
    twc_bus_t bus_en;
    twc_cursor_t cursor_cmd;
    logic [4:0] acc_cmd;
    logic [3:0] acc_bus;
    int num_errors, comparisons, n_home;
    // Character, detector flags, {plot, defeat, no-wrap}, expected enables and moves
    logic [7:0] t_chr [13] = '{8'h41, 8'h01, 8'h7f, 8'h07, 8'h08, 8'h0a, 8'h0d, 8'h0d, 8'h0a, 8'h01, 8'h42, 8'h43,
        8'h0d};
    logic [6:0] t_spc [13] = '{7'h00, 7'h04, 7'h02, 7'h0c, 7'h14, 7'h24, 7'h45, 7'h44, 7'h24, 7'h04, 7'h00, 7'h00,
        7'h44};
    logic [2:0] t_mode [13] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h4, 3'h2, 3'h1, 3'h4};
    logic [3:0] t_bus [13] = '{4'he, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'he, 4'h6, 4'he, 4'he, 4'he, 4'he, 4'he};
    logic [4:0] t_cmd [13] = '{5'h10, 5'h00, 5'h00, 5'h00, 5'h08, 5'h02, 5'h04, 5'h04, 5'h10, 5'h10, 5'h00, 5'h00,
        5'h10};
    logic [4:0] t_key [4] = '{5'h10, 5'h08, 5'h02, 5'h01};

    twc_ctrl dut (
        .clk_sys, .rst_n, .timing, .erase_line_key, .erase_page_key, .home_key, .cursor_keys, .scan_active,
        .vertical_blank_n, .scan_h_count, .scan_row_end, .short_form, .plot_mode, .auto_carry, .count_up_defeat,
        .line_end_no_wrap, .h_line_end, .block_line_end, .serial_rx_available, .parallel_key_available,
        .serial_tx_empty, .parallel_out_empty, .rx_data, .special, .rx_ready, .bus_data, .bus_en, .cursor_cmd,
        .home_load, .erase_busy
    );

    twc_io_model io (
        .clk_sys, .req, .req_data, .req_spec, .hold_busy, .bus_en, .serial_rx_available, .parallel_key_available,
        .rx_data, .special, .serial_tx_empty, .parallel_out_empty
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ************************************
    // Access tasks
    // ************************************
    task automatic complete_run();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    // Sample settled outputs just after the edge, then hand back for driving
    task automatic tick();
        @(posedge clk_sys);
        #10;
        acc_cmd = acc_cmd | cursor_cmd;
        acc_bus = acc_bus | bus_en;
        if (bus_en !== 4'h0)
            last_data = bus_data;
        if (home_load === 1'b1)
            n_home++;
    endtask : tick

    task automatic strobe(input logic [4:0] tm, input logic [1:0] sm);
        acc_cmd = '0;
        acc_bus = '0;
        last_data = '0;
        n_home = 0;
        timing = tm;
        {scan_h_count, scan_row_end} = sm;
        tick();
        timing = '0;
        {scan_h_count, scan_row_end} = 2'b00;
        repeat (3) tick();
    endtask : strobe

    task automatic send(input logic [7:0] c, input logic [6:0] s);
        req_data = c;
        req_spec = s;
        req = 1'b1;
        tick();
        req = 1'b0;
        repeat (5) tick();
    endtask : send

    task automatic xfer(input logic [7:0] c, input logic [6:0] s, input logic [3:0] eb, input logic [4:0] ec);
        send(c, s);
        strobe(T0B2, 2'b00);
        `CHK(acc_bus, eb)
        `CHK(last_data, c)
        strobe(T1C, 2'b00);
        `CHK(acc_cmd, ec)
    endtask : xfer

    // Hang guard well beyond the longest sequence
    initial
    begin
        #5000000;
        num_errors++;
        complete_run();
    end

    // ************************************
    // Main sequence
    // ************************************
    initial
    begin
        {rst_n, req, hold_busy, erase_line_key, erase_page_key, home_key, scan_active, scan_h_count} = '0;
        {scan_row_end, short_form, plot_mode, auto_carry, count_up_defeat, line_end_no_wrap} = '0;
        {h_line_end, block_line_end, cursor_keys, timing, req_data, req_spec} = '0;
        vertical_blank_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        #10;
        `CHK({rx_ready, bus_en, cursor_cmd, home_load, erase_busy}, 12'h000)
        rst_n = 1'b1;
        repeat (3) tick();
        `CHK(rx_ready, 1'b1)
        for (int i = 0; i < 13; i++)
        begin
            {plot_mode, count_up_defeat, line_end_no_wrap} = t_mode[i];
            xfer(t_chr[i], t_spc[i], t_bus[i], t_cmd[i]);
        end
        {plot_mode, count_up_defeat, line_end_no_wrap} = 3'h0;
        // Busy sinks hold the transfer back, then it goes through
        hold_busy = 1'b1;
        send(8'h44, 7'h00);
        strobe(T0B2, 2'b00);
        `CHK(acc_bus, 4'h0)
        hold_busy = 1'b0;
        repeat (3) tick();
        strobe(T0B2, 2'b00);
        `CHK(last_data, 8'h44)
        strobe(T1C, 2'b00);
        // Fill the buffer past full while sinks stall, then drain in order
        hold_busy = 1'b1;
        for (int i = 0; i < 9; i++)
            send(8'(i) + 8'h50, 7'h00);
        `CHK(rx_ready, 1'b0)
        hold_busy = 1'b0;
        repeat (3) tick();
        for (int i = 0; i < 9; i++)
        begin
            strobe(T0B2, 2'b00);
            `CHK(last_data, (i < 8) ? 8'(i) + 8'h50 : 8'h00)
            repeat (4) tick();
        end
        `CHK(rx_ready, 1'b1)
        strobe(T1C, 2'b00);
        // Cursor keys give one move each, none once cycle 3 has cleared the latch
        scan_active = 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            cursor_keys = 4'h1 << (k % 4);
            repeat (3) tick();
            cursor_keys = 4'h0;
            repeat (3) tick();
            if (k == 4)
                strobe(T3, 2'b00);
            strobe(T1C, 2'b00);
            `CHK(acc_cmd, (k < 4) ? t_key[k] : 5'h00)
            strobe(T1C, 2'b00);
            `CHK(acc_cmd, 5'h00)
        end
        // Scan counting, plot and blanking suppression
        strobe(5'h00, 2'b01);
        `CHK(acc_cmd, 5'h02)
        strobe(5'h00, 2'b10);
        `CHK(acc_cmd, 5'h10)
        plot_mode = 1'b1;
        strobe(5'h00, 2'b01);
        `CHK(acc_cmd, 5'h00)
        plot_mode = 1'b0;
        vertical_blank_n = 1'b0;
        repeat (3) tick();
        strobe(5'h00, 2'b01);
        `CHK(acc_cmd, 5'h00)
        strobe(5'h00, 2'b10);
        `CHK(acc_cmd, 5'h00)
        vertical_blank_n = 1'b1;
        scan_active = 1'b0;
        // Erase to end of line, short form then long form
        short_form = 1'b1;
        erase_line_key = 1'b1;
        repeat (3) tick();
        strobe(T2, 2'b00);
        erase_line_key = 1'b0;
        `CHK(erase_busy, 1'b1)
        `CHK(acc_bus, 4'h9)
        `CHK(last_data, SPACE_CODE)
        `CHK(acc_cmd, 5'h10)
        h_line_end = 1'b1;
        repeat (2) tick();
        strobe(5'h00, 2'b00);
        `CHK(acc_bus, 4'h0)
        strobe(T3, 2'b00);
        `CHK(erase_busy, 1'b0)
        short_form = 1'b0;
        erase_line_key = 1'b1;
        repeat (3) tick();
        strobe(T2, 2'b00);
        erase_line_key = 1'b0;
        strobe(5'h00, 2'b00);
        `CHK(acc_bus, 4'h9)
        block_line_end = 1'b1;
        repeat (2) tick();
        strobe(5'h00, 2'b00);
        `CHK(acc_bus, 4'h0)
        strobe(T3, 2'b00);
        {h_line_end, block_line_end} = 2'b00;
        // Erase page holds through cycle 3, then homes the cursor once
        erase_page_key = 1'b1;
        repeat (3) tick();
        strobe(T3, 2'b00);
        `CHK(erase_busy, 1'b1)
        erase_page_key = 1'b0;
        repeat (3) tick();
        strobe(T3, 2'b00);
        `CHK(erase_busy, 1'b0)
        strobe(T7C, 2'b00);
        `CHK(n_home, 1)
        strobe(T7C, 2'b00);
        `CHK(n_home, 0)
        home_key = 1'b1;
        repeat (3) tick();
        strobe(T7C, 2'b00);
        home_key = 1'b0;
        `CHK(n_home, 1)
        complete_run();
    end
endmodule : tb_twc_ctrl
